// [rtl/hsstc_pkg.sv]
/*
  Constants for the high-side switch timer and source control block:
  register addresses, field positions, codes and timer lengths.
  Assumes a 40 MHz mclk.
*/
`default_nettype none
package hsstc_pkg;
  localparam int CLK_HZ = 40000000;
  // Register addresses (7-bit frame address)
  localparam logic [6:0] ADDR_TIMER_SETUP = 7'h0d;
  localparam logic [6:0] ADDR_FAULT_POLICY = 7'h10;
  localparam logic [6:0] ADDR_PAIR_A = 7'h14;
  localparam logic [6:0] ADDR_PAIR_B = 7'h15;
  // Writable bit masks, reserved bits read zero
  localparam logic [7:0] MASK_TIMER = 8'h77;
  localparam logic [7:0] MASK_POLICY = 8'h70;
  localparam logic [7:0] MASK_PAIR = 8'h77;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  // Field positions
  localparam int ON_LSB = 4;
  localparam int PER_LSB = 0;
  localparam int SRC_LO_LSB = 0;
  localparam int SRC_HI_LSB = 4;
  localparam int OV_DIS_BIT = 6;
  localparam int UV_DIS_BIT = 5;
  localparam int REC_EN_BIT = 4;
  // On-time codes
  localparam logic [2:0] ON_OFF_LOW = 3'h0;
  localparam logic [2:0] ON_OFF_HIGH = 3'h6;
  localparam logic [2:0] ON_RESERVED = 3'h7;
  // Source codes
  localparam logic [2:0] SRC_OFF = 3'h0;
  localparam logic [2:0] SRC_ON = 3'h1;
  localparam logic [2:0] SRC_TMR1 = 3'h2;
  localparam logic [2:0] SRC_TMR2 = 3'h3;
  localparam logic [2:0] SRC_FIRST_PWM_CHANNEL = 3'h4;
  localparam logic [2:0] SRC_SECOND_PWM_CHANNEL = 3'h5;
  // On-times in microseconds, periods in milliseconds
  localparam int ON_US_1 = 100;
  localparam int ON_US_2 = 300;
  localparam int ON_US_3 = 1000;
  localparam int ON_US_4 = 10000;
  localparam int ON_US_5 = 20000;
  localparam int PER_MS_0 = 10;
  localparam int PER_MS_1 = 20;
  localparam int PER_MS_2 = 50;
  localparam int PER_MS_3 = 100;
  localparam int PER_MS_4 = 200;
  localparam int PER_MS_5 = 1000;
  localparam int PER_MS_6 = 2000;
  localparam int CYC_PER_US = CLK_HZ / 1000000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CNT_W = 27;
  typedef enum logic [1:0] {
    HSSTC_IDLE = 2'b01,
    HSSTC_RUN = 2'b10
  } hsstc_tstate_t;
endpackage
`default_nettype wire

// [rtl/hsstc_top.sv]
/*
  Register bank and second cyclic timer for four high-side switch outputs.
  Assumes a decoded register frame (address, write strobe, data) from the
  serial interface, synchronous fault inputs and an external first timer
  and PWM channels.
*/
`default_nettype none
module hsstc_top
  import hsstc_pkg::*;
(
  input wire logic mclk, // 40 MHz clock
  input wire logic rst, // Async reset, active high
  input wire logic clk_en, // Freezes all state when low
  input wire logic restart_state, // Restart mode entry pulse
  input wire logic [6:0] reg_addr, // Frame address
  input wire logic reg_wr, // Write strobe, one cycle
  input wire logic [7:0] reg_wdata, // Frame data byte
  output logic [7:0] reg_rdata, // Read data
  input wire logic first_cyclic_timer, // First timer output
  input wire logic first_pwm_channel, // First PWM output
  input wire logic second_pwm_channel, // Second PWM output
  input wire logic supply_ov, // Switch supply overvoltage
  input wire logic supply_uv, // Switch supply undervoltage
  input wire logic [3:0] switch_fault, // Overcurrent/overtemp per switch
  output logic [3:0] switch_out // Switch drive
);
  logic [7:0] timer_reg;
  logic [7:0] policy_reg;
  logic [7:0] pair_a_reg;
  logic [7:0] pair_b_reg;
  logic [2:0] src [4];
  logic [2:0] second_timer_on_time;
  logic [2:0] second_timer_period;
  logic second_cyclic_timer;
  logic shutdown;
  logic fault_seen_reg;
  logic [3:0] drive;
  logic wr_timer;
  logic cyclic_used;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] on_cyc;
  logic [CNT_W-1:0] per_cyc;
  hsstc_tstate_t tstate_reg;

  assign second_timer_on_time = timer_reg[ON_LSB +: 3];
  assign second_timer_period = timer_reg[PER_LSB +: 3];
  assign src[0] = pair_a_reg[SRC_LO_LSB +: 3];
  assign src[1] = pair_a_reg[SRC_HI_LSB +: 3];
  assign src[2] = pair_b_reg[SRC_LO_LSB +: 3];
  assign src[3] = pair_b_reg[SRC_HI_LSB +: 3];
  assign wr_timer = reg_wr && reg_addr == ADDR_TIMER_SETUP;
  assign cyclic_used = (src[0] == SRC_TMR2) || (src[1] == SRC_TMR2) ||
                       (src[2] == SRC_TMR2) || (src[3] == SRC_TMR2);

  // ****************************************
  // Register bank
  // ****************************************
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      timer_reg <= RESET_VALUE;
      policy_reg <= RESET_VALUE;
    end
    else if (clk_en)
    begin
      if (restart_state)
      begin
        policy_reg <= policy_reg & MASK_POLICY;
        timer_reg <= RESET_VALUE;
      end
      else
      begin
        if (wr_timer)
          timer_reg <= reg_wdata & MASK_TIMER;
        if (reg_wr && reg_addr == ADDR_FAULT_POLICY)
          policy_reg <= reg_wdata & MASK_POLICY;
      end
    end
  end

  // Hardware fault clear wins over a software write in the same cycle
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pair_a_reg <= RESET_VALUE;
      pair_b_reg <= RESET_VALUE;
    end
    else if (clk_en)
    begin
      if (restart_state)
      begin
        pair_a_reg <= RESET_VALUE;
        pair_b_reg <= RESET_VALUE;
      end
      else
      begin
        pair_a_reg <= ((reg_wr && reg_addr == ADDR_PAIR_A) ? (reg_wdata & MASK_PAIR) : pair_a_reg)
                      & ~{1'b0, {3{switch_fault[1]}}, 1'b0, {3{switch_fault[0]}}};
        pair_b_reg <= ((reg_wr && reg_addr == ADDR_PAIR_B) ? (reg_wdata & MASK_PAIR) : pair_b_reg)
                      & ~{1'b0, {3{switch_fault[3]}}, 1'b0, {3{switch_fault[2]}}};
      end
    end
  end

  // Address decode of the frame; mode bit is handled by the serial front end
  always_comb
  begin
    unique case (reg_addr)
      ADDR_TIMER_SETUP: reg_rdata = timer_reg;
      ADDR_FAULT_POLICY: reg_rdata = policy_reg;
      ADDR_PAIR_A: reg_rdata = pair_a_reg;
      ADDR_PAIR_B: reg_rdata = pair_b_reg;
      default: reg_rdata = RESET_VALUE;
    endcase
  end

  // ****************************************
  // Second cyclic timer
  // ****************************************
  always_comb
  begin
    unique case (second_timer_on_time)
      3'h1: on_cyc = CNT_W'(ON_US_1 * CYC_PER_US);
      3'h2: on_cyc = CNT_W'(ON_US_2 * CYC_PER_US);
      3'h3: on_cyc = CNT_W'(ON_US_3 * CYC_PER_US);
      3'h4: on_cyc = CNT_W'(ON_US_4 * CYC_PER_US);
      3'h5: on_cyc = CNT_W'(ON_US_5 * CYC_PER_US);
      default: on_cyc = '0;
    endcase
    unique case (second_timer_period)
      3'h0: per_cyc = CNT_W'(PER_MS_0 * CYC_PER_MS);
      3'h1: per_cyc = CNT_W'(PER_MS_1 * CYC_PER_MS);
      3'h2: per_cyc = CNT_W'(PER_MS_2 * CYC_PER_MS);
      3'h3: per_cyc = CNT_W'(PER_MS_3 * CYC_PER_MS);
      3'h4: per_cyc = CNT_W'(PER_MS_4 * CYC_PER_MS);
      3'h5: per_cyc = CNT_W'(PER_MS_5 * CYC_PER_MS);
      3'h6: per_cyc = CNT_W'(PER_MS_6 * CYC_PER_MS);
      default: per_cyc = CNT_W'(PER_MS_6 * CYC_PER_MS);
    endcase
  end

  function automatic logic on_cyc_w(input logic [2:0] code);
    on_cyc_w = code != ON_OFF_LOW && code != ON_OFF_HIGH && code != ON_RESERVED;
  endfunction

  // Rewriting the register restarts the cycle from the period start
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tstate_reg <= HSSTC_IDLE;
      cnt_reg <= '0;
    end
    else if (clk_en)
    begin
      unique case (tstate_reg)
        HSSTC_IDLE:
          if (wr_timer && !restart_state && on_cyc_w(reg_wdata[ON_LSB +: 3]))
          begin
            tstate_reg <= HSSTC_RUN;
            cnt_reg <= '0;
          end
        HSSTC_RUN:
          if (on_cyc == '0 || restart_state)
            tstate_reg <= HSSTC_IDLE;
          else if (wr_timer)
            cnt_reg <= '0;
          else if (cnt_reg >= per_cyc - CNT_W'(1))
            cnt_reg <= '0;
          else
            cnt_reg <= cnt_reg + CNT_W'(1);
      endcase
    end
  end

  always_comb
  begin
    if (second_timer_on_time == ON_OFF_HIGH)
      second_cyclic_timer = 1'b1;
    else if (tstate_reg == HSSTC_RUN && on_cyc != '0)
      second_cyclic_timer = cnt_reg < on_cyc;
    else
      second_cyclic_timer = 1'b0;
  end

  // ****************************************
  // Source select and supply fault policy
  // ****************************************
  assign shutdown = (supply_ov && !policy_reg[OV_DIS_BIT]) ||
                    (supply_uv && !policy_reg[UV_DIS_BIT]);

  // Latches that a shutdown happened so recovery can be withheld
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      fault_seen_reg <= 1'b0;
    else if (clk_en)
    begin
      if (shutdown)
        fault_seen_reg <= 1'b1;
      else if (policy_reg[REC_EN_BIT] || restart_state)
        fault_seen_reg <= 1'b0;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sw
      always_comb
      begin
        unique case (src[gi])
          SRC_OFF: drive[gi] = 1'b0;
          SRC_ON: drive[gi] = 1'b1;
          SRC_TMR1: drive[gi] = first_cyclic_timer;
          SRC_TMR2: drive[gi] = second_cyclic_timer;
          SRC_FIRST_PWM_CHANNEL: drive[gi] = first_pwm_channel;
          SRC_SECOND_PWM_CHANNEL: drive[gi] = second_pwm_channel;
          default: drive[gi] = 1'b0;
        endcase
      end
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          switch_out[gi] <= 1'b0;
        else if (clk_en)
          switch_out[gi] <= drive[gi] && !shutdown && !fault_seen_reg;
      end
    end
  endgenerate

  // ****************************************
  // Checks
  // ****************************************
  property p_reserved_zero;
    @(posedge mclk) disable iff (rst) (reg_rdata & ~(MASK_TIMER | MASK_POLICY)) == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit read nonzero");
  property p_ov_off;
    @(posedge mclk) disable iff (rst) clk_en && supply_ov && !policy_reg[OV_DIS_BIT] |=> switch_out == 4'h0;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("switch on during overvoltage");
  property p_uv_off;
    @(posedge mclk) disable iff (rst) clk_en && supply_uv && !policy_reg[UV_DIS_BIT] |=> switch_out == 4'h0;
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("switch on during undervoltage");
  property p_no_recover;
    @(posedge mclk) disable iff (rst) clk_en && shutdown && !policy_reg[REC_EN_BIT] ##1 clk_en && !restart_state
      |=> switch_out == 4'h0;
  endproperty
  a_no_recover: assert property (p_no_recover) else $error("switch recovered without enable");
  property p_fault_clear;
    @(posedge mclk) disable iff (rst) clk_en && switch_fault[0] |=> src[0] == SRC_OFF;
  endproperty
  a_fault_clear: assert property (p_fault_clear) else $error("fault did not clear source");
  property p_restart;
    @(posedge mclk) disable iff (rst) clk_en && restart_state |=> timer_reg == 8'h00 && pair_a_reg == 8'h00
      && pair_b_reg == 8'h00 && policy_reg == $past(policy_reg);
  endproperty
  a_restart: assert property (p_restart) else $error("restart clear wrong");
  property p_start;
    @(posedge mclk) disable iff (rst) clk_en && wr_timer && !restart_state && reg_wdata[ON_LSB +: 3] == 3'h1
      |=> tstate_reg == HSSTC_RUN ##0 second_cyclic_timer;
  endproperty
  a_start: assert property (p_start) else $error("timer did not start");
  property p_high_code;
    @(posedge mclk) disable iff (rst) second_timer_on_time == ON_OFF_HIGH |-> second_cyclic_timer;
  endproperty
  a_high_code: assert property (p_high_code) else $error("off-high code not high");
  property p_low_code;
    @(posedge mclk) disable iff (rst) second_timer_on_time == ON_OFF_LOW |-> !second_cyclic_timer;
  endproperty
  a_low_code: assert property (p_low_code) else $error("off-low code not low");
  property p_on_src;
    @(posedge mclk) disable iff (rst) clk_en && src[0] == SRC_ON && !shutdown && !fault_seen_reg |=> switch_out[0];
  endproperty
  a_on_src: assert property (p_on_src) else $error("forced-on switch is off");
  c_timer_run: cover property (@(posedge mclk) disable iff (rst) tstate_reg == HSSTC_RUN && second_cyclic_timer);
  c_shutdown: cover property (@(posedge mclk) disable iff (rst) shutdown && switch_out == 4'h0);
  c_fault: cover property (@(posedge mclk) disable iff (rst) |switch_fault);
  c_restart_cyclic: cover property (@(posedge mclk) disable iff (rst) restart_state && cyclic_used);
endmodule
`default_nettype wire

// [test/hsstc_load_model.sv]
/*
  Model of the far side: the first cyclic timer and both PWM channels
  as square waves of distinct rates.
  Assumes a free-running mclk; outputs change just after its rising edge.
*/
`default_nettype none
module hsstc_load_model (
  input wire logic mclk, // Clock
  input wire logic rst, // Async reset, active high
  output logic first_cyclic_timer, // Slow wave
  output logic first_pwm_channel, // Medium wave
  output logic second_pwm_channel // Fast wave
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [5:0] cnt_reg;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cnt_reg <= 6'h00;
    else
      cnt_reg <= cnt_reg + 6'h01;
  end
  // Distinct rates, so a wrong source select shows as a mismatch
  assign first_cyclic_timer = cnt_reg[5];
  assign first_pwm_channel = cnt_reg[3];
  assign second_pwm_channel = cnt_reg[1];
endmodule
`default_nettype wire

// [test/high_side_switch_timer_control_tb_top.sv]
/*
  Self-checking bench for the switch source and second timer block.
  Assumes the register frame is already decoded to address, strobe, data.
*/
`default_nettype none
`define CHK(got, exp, msg) begin comparisons++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("BAD %0t %s", $time, msg); end end
module high_side_switch_timer_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import hsstc_pkg::*;
  logic mclk, rst, clk_en, restart_state, reg_wr, supply_ov, supply_uv, t1, p1, p2;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [3:0] switch_fault, switch_out;
  logic [2:0] srcd;
  int n_mismatch, comparisons, cyc;

  hsstc_top u_dut (.mclk(mclk), .rst(rst), .clk_en(clk_en), .restart_state(restart_state),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .first_cyclic_timer(t1), .first_pwm_channel(p1), .second_pwm_channel(p2),
    .supply_ov(supply_ov), .supply_uv(supply_uv), .switch_fault(switch_fault), .switch_out(switch_out));
  hsstc_load_model u_load (.mclk(mclk), .rst(rst), .first_cyclic_timer(t1),
    .first_pwm_channel(p1), .second_pwm_channel(p2));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Sources as the design sees them at each edge
  always @(posedge mclk)
    srcd <= {p2, p1, t1};

  // ****************
  // Support tasks
  // ****************
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
    @(posedge mclk);
    reg_addr <= a;
    @(negedge mclk);
    `CHK(reg_rdata, e, "register read")
    // Return on a rising edge so the next stimulus lands there
    @(posedge mclk);
  endtask

  task automatic out_chk(input logic [3:0] e);
    idle(3);
    @(negedge mclk);
    `CHK(switch_out, e, "switch drive")
    @(posedge mclk);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_regs();
    rd_chk(ADDR_TIMER_SETUP, 8'h00);
    rd_chk(ADDR_FAULT_POLICY, 8'h00);
    rd_chk(ADDR_PAIR_A, 8'h00);
    rd_chk(ADDR_PAIR_B, 8'h00);
    rd_chk(7'h11, 8'h00);
    wr(ADDR_TIMER_SETUP, 8'he9);
    rd_chk(ADDR_TIMER_SETUP, 8'h61);
    wr(ADDR_FAULT_POLICY, 8'hff);
    rd_chk(ADDR_FAULT_POLICY, 8'h70);
    wr(ADDR_PAIR_A, 8'hdd);
    rd_chk(ADDR_PAIR_A, 8'h55);
    wr(ADDR_PAIR_B, 8'hdd);
    rd_chk(ADDR_PAIR_B, 8'h55);
    wr(ADDR_TIMER_SETUP, 8'h00);
    wr(ADDR_FAULT_POLICY, 8'h00);
    wr(ADDR_PAIR_B, 8'h00);
  endtask

  task automatic t_sources();
    logic e;
    // Reserved codes 110 and 111 are never written here
    for (int c = 0; c < 6; c++)
    begin
      wr(ADDR_PAIR_A, {5'h00, c[2:0]});
      idle(3);
      repeat (70)
      begin
        @(negedge mclk);
        e = (c == 1) ? 1'b1 : (c == 2) ? srcd[0] : (c == 4) ? srcd[1] : (c == 5) ? srcd[2] : 1'b0;
        `CHK(switch_out[0], e, "source select")
      end
    end
    wr(ADDR_PAIR_A, 8'h10);
    wr(ADDR_PAIR_B, 8'h11);
    out_chk(4'he);
    wr(ADDR_PAIR_B, 8'h00);
  endtask

  task automatic t_timer();
    int on_cyc[3];
    on_cyc = '{ON_US_1 * CYC_PER_US, ON_US_2 * CYC_PER_US, ON_US_3 * CYC_PER_US};
    wr(ADDR_PAIR_A, {5'h00, SRC_TMR2});
    wr(ADDR_TIMER_SETUP, 8'h60);
    out_chk(4'h1);
    wr(ADDR_TIMER_SETUP, 8'h00);
    out_chk(4'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_TIMER_SETUP, {1'b0, 3'(i + 1), 4'h0});
      out_chk(4'h1);
      idle(on_cyc[i] - 100);
      out_chk(4'h1);
      idle(200);
      out_chk(4'h0);
    end
    wr(ADDR_TIMER_SETUP, 8'h00);
  endtask

  task automatic t_faults();
    wr(ADDR_PAIR_A, 8'h21);
    @(posedge mclk);
    switch_fault <= 4'h1;
    @(posedge mclk);
    switch_fault <= 4'h0;
    rd_chk(ADDR_PAIR_A, 8'h20);
    wr(ADDR_PAIR_A, 8'h11);
    out_chk(4'h3);
    supply_ov <= 1'b1;
    out_chk(4'h0);
    supply_ov <= 1'b0;
    out_chk(4'h0);
    wr(ADDR_FAULT_POLICY, 8'h10);
    out_chk(4'h3);
    supply_uv <= 1'b1;
    out_chk(4'h0);
    supply_uv <= 1'b0;
    out_chk(4'h3);
    wr(ADDR_FAULT_POLICY, 8'h70);
    @(posedge mclk);
    supply_ov <= 1'b1;
    supply_uv <= 1'b1;
    out_chk(4'h3);
    supply_ov <= 1'b0;
    supply_uv <= 1'b0;
  endtask

  task automatic t_restart();
    wr(ADDR_TIMER_SETUP, 8'h25);
    wr(ADDR_PAIR_B, 8'h33);
    @(posedge mclk);
    restart_state <= 1'b1;
    @(posedge mclk);
    restart_state <= 1'b0;
    rd_chk(ADDR_FAULT_POLICY, 8'h70);
    rd_chk(ADDR_TIMER_SETUP, 8'h00);
    rd_chk(ADDR_PAIR_A, 8'h00);
    rd_chk(ADDR_PAIR_B, 8'h00);
    // Frozen clock enable must drop the write
    clk_en <= 1'b0;
    wr(ADDR_PAIR_A, 8'h01);
    clk_en <= 1'b1;
    rd_chk(ADDR_PAIR_A, 8'h00);
  endtask

  initial
  begin
    rst = 1'b1;
    clk_en = 1'b1;
    restart_state = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    supply_ov = 1'b0;
    supply_uv = 1'b0;
    switch_fault = 4'h0;
    idle(8);
    rst <= 1'b0;
    t_regs();
    t_sources();
    t_timer();
    t_faults();
    t_restart();
    give_verdict();
  end
endmodule
`default_nettype wire
